// >>> common/tbio_defines.vh
// Constants for the register-B pin select block of timer channels 1 and 2
// Behaviour
// R01 - With select bit 3 low, register B compares; 0000 or 0100 leave the pin undriven, 0001 starts low and 0101 starts high, and both drive low on each match.
// R02 - Select 0010 starts the pin low and 0110 starts it high, and both drive it high on each compare match.
// R03 - Select 0011 starts the pin low and 0111 starts it high, and both invert the pin on each compare match.
// R04 - With select bit 3 high and low bits 00, register B captures the counter on a rising pin edge; channel 2 ignores select bit 2 in capture mode.
// R05 - In capture mode with low bits 01, register B captures the counter on a falling pin edge.
// R06 - In capture mode with select bit 1 set, register B captures on both pin edges whatever select bit 0 holds.
// R07 - On channel 1, select bits 3 and 2 both high make register B capture on each channel-0 register-C match or capture event instead of a pin edge.
// R08 - The select field is read/write, reads back the last value written and governs every match and capture after the write.
`ifndef TBIO_DEFINES_VH
`define TBIO_DEFINES_VH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define TBIO_OFF_CH1_CTL 8'h00
`define TBIO_OFF_CH2_CTL 8'h04
`define TBIO_OFF_CH1_GRB 8'h08
`define TBIO_OFF_CH2_GRB 8'h0C
`define TBIO_OFF_STATUS 8'h10

// ****************************************
// Fields and reset values
// ****************************************
`define TBIO_SEL_LSB 4
`define TBIO_SEL_MSB 7
`define TBIO_SEL_RESET 4'h0
`define TBIO_GRB_RESET 16'h0000

// ****************************************
// Bus answers
// ****************************************
`define TBIO_RESP_OKAY 2'h0
`define TBIO_RESP_SLVERR 2'h2

`endif

// >>> core/tbio_channel.v
// One channel's register B: compare pin driver and input capture
`timescale 1ns/1ps
`include "tbio_defines.vh"
module tbio_channel #(
  parameter HAS_LINK = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] sel,
  input wire sel_wr,
  input wire [15:0] count,
  input wire pin_in,
  input wire link_event,
  input wire gr_wr,
  input wire [15:0] gr_wdata,
  output reg [15:0] gr_reg,
  output reg pin_out_reg,
  output reg pin_oe_reg
);
  reg pin_d_reg;
  reg eq_d_reg;
  wire rise;
  wire fall;
  wire eq;
  wire match;
  wire capture;

  // Capture trigger decode for the current select
  function cap_hit;
    input [3:0] s;
    input r;
    input f;
    input lk;
    begin
      if (HAS_LINK != 0 && s[2])
        cap_hit = lk; // [R07]
      else if (s[1])
        cap_hit = r | f; // [R06]
      else if (s[0])
        cap_hit = f; // [R05]
      else
        cap_hit = r; // [R04]
    end
  endfunction

  // Edges of the synchronised pin, match as the rise of equality
  assign rise = pin_in & ~pin_d_reg;
  assign fall = ~pin_in & pin_d_reg;
  assign eq = (count == gr_reg);
  assign match = eq & ~eq_d_reg & ~sel[3];
  assign capture = sel[3] & cap_hit(sel, rise, fall, link_event); // [R08]

  // History for edge and match detection
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_d_reg <= 1'h0;
      eq_d_reg <= 1'h0;
    end else begin
      pin_d_reg <= pin_in;
      eq_d_reg <= eq;
    end
  end

  // Register B; a capture beats a software write in the same cycle
  always @(posedge aclk) begin
    if (!aresetn)
      gr_reg <= `TBIO_GRB_RESET;
    else if (capture)
      gr_reg <= count; // [R04] [R05] [R06] [R07]
    else if (gr_wr)
      gr_reg <= gr_wdata;
  end

  // Pin driver: initial level on a select write, action on match
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_reg <= 1'h0;
      pin_oe_reg <= 1'h0;
    end else if (sel_wr) begin
      pin_oe_reg <= ~sel[3] & (|sel[1:0]); // [R01]
      pin_out_reg <= ~sel[3] & (|sel[1:0]) & sel[2]; // [R01] [R02] [R03] [R08]
    end else if (match) begin
      case (sel[1:0])
        2'h1: pin_out_reg <= 1'h0; // [R01]
        2'h2: pin_out_reg <= 1'h1; // [R02]
        2'h3: pin_out_reg <= ~pin_out_reg; // [R03]
        default: pin_out_reg <= pin_out_reg;
      endcase
    end
  end
endmodule

// >>> core/tbio_sync.v
// Two-stage synchroniser for one pin level
`timescale 1ns/1ps
module tbio_sync (
  input wire aclk,
  input wire aresetn,
  input wire async_in,
  output reg sync_out_reg
);
  reg meta_reg;

  // First stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'h0;
      sync_out_reg <= 1'h0;
    end else begin
      meta_reg <= async_in;
      sync_out_reg <= meta_reg;
    end
  end
endmodule

// >>> core/tbio_top.v
// Register-B pin select for timer channels 1 and 2 behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "tbio_defines.vh"
// Map: selects at 0x00 and 0x04 in bits 7:4, register B at 0x08 and 0x0C
// in bits 15:0, read-only pin status at 0x10.
// Word decode ignores address bits 1:0, so 0x11 to 0x13 also reach status.
// Write answer one edge after both halves are held; read answer one edge
// after the address is taken.
// Select writes reach a channel one edge later, with a strobe, so the
// initial pin level shows two edges after the write is decoded.
// Register-B writes are merged by lane first; a same-cycle capture wins.
module tbio_top (
  input wire aclk,
  input wire aresetn,
  // Write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // Write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // Read address and data
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Counters and channel-0 event, same clock
  input wire [15:0] ch1_count,
  input wire [15:0] ch2_count,
  input wire ch0_general_reg_c_event,
  // Channel pins, asynchronous inputs
  input wire ch1_pin_b_in,
  output wire ch1_pin_b_out,
  output wire ch1_pin_b_oe,
  input wire ch2_pin_b_in,
  output wire ch2_pin_b_out,
  output wire ch2_pin_b_oe
);

  // ****************************************
  // Declarations
  // ****************************************
  reg [7:0] awaddr_reg;
  reg aw_have_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg w_have_reg;
  reg [3:0] ch1_sel_reg;
  reg [3:0] ch2_sel_reg;
  reg ch1_sel_wr_reg;
  reg ch2_sel_wr_reg;
  reg ch1_gr_wr_reg;
  reg ch2_gr_wr_reg;
  reg [15:0] gr_wdata_reg;
  reg [31:0] rd_next;
  reg rd_hit_next;
  wire do_write;
  wire wr_ch1_ctl;
  wire wr_ch2_ctl;
  wire wr_ch1_grb;
  wire wr_ch2_grb;
  wire wr_hit;
  wire ch1_pin_sync;
  wire ch2_pin_sync;
  wire [15:0] ch1_gr;
  wire [15:0] ch2_gr;
  wire [3:0] status_word;

  // ****************************************
  // Helpers
  // ****************************************

  // Merge one byte lane set into an old 16-bit value
  function [15:0] lane_merge;
    input [15:0] old;
    input [15:0] din;
    input [1:0] strb;
    begin
      lane_merge[7:0] = strb[0] ? din[7:0] : old[7:0];
      lane_merge[15:8] = strb[1] ? din[15:8] : old[15:8];
    end
  endfunction

  // Word index compare, ignoring the low two address bits
  function addr_is;
    input [7:0] a;
    input [7:0] off;
    begin
      addr_is = (a[7:2] == off[7:2]);
    end
  endfunction

  // Bus answer for a hit or a miss, shared by both answer channels
  function [1:0] resp_code;
    input hit;
    begin
      resp_code = hit ? `TBIO_RESP_OKAY : `TBIO_RESP_SLVERR;
    end
  endfunction

  // ****************************************
  // Write channel
  // ****************************************

  // Address and data land together or apart; the write waits for both
  assign do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  assign wr_ch1_ctl = do_write & addr_is(awaddr_reg, `TBIO_OFF_CH1_CTL);
  assign wr_ch2_ctl = do_write & addr_is(awaddr_reg, `TBIO_OFF_CH2_CTL);
  assign wr_ch1_grb = do_write & addr_is(awaddr_reg, `TBIO_OFF_CH1_GRB);
  assign wr_ch2_grb = do_write & addr_is(awaddr_reg, `TBIO_OFF_CH2_GRB);
  // Status counts as a hit, so a write there answers OKAY and is dropped
  assign wr_hit = wr_ch1_ctl | wr_ch2_ctl | wr_ch1_grb | wr_ch2_grb
    | addr_is(awaddr_reg, `TBIO_OFF_STATUS);

  // Write address acceptance
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'h0;
      aw_have_reg <= 1'h0;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'h0;
      aw_have_reg <= 1'h1;
      awaddr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_reg <= 1'h0;
    end else if (!aw_have_reg && !s_axi_bvalid) begin
      s_axi_awready <= 1'h1;
    end
  end

  // Write data acceptance
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'h0;
      w_have_reg <= 1'h0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'h0;
      w_have_reg <= 1'h1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_have_reg <= 1'h0;
    end else if (!w_have_reg && !s_axi_bvalid) begin
      s_axi_wready <= 1'h1;
    end
  end

  // Write response; status is read-only so writes there are dropped quietly
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= `TBIO_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'h1;
      s_axi_bresp <= resp_code(wr_hit);
    end else if (s_axi_bready && s_axi_bvalid) begin
      s_axi_bvalid <= 1'h0;
    end
  end

  // ****************************************
  // Select registers
  // ****************************************

  // Select field in byte lane 0; the strobe pulse follows one edge later
  // so the channels see the new select together with the pulse
  always @(posedge aclk) begin
    if (!aresetn) begin
      ch1_sel_reg <= `TBIO_SEL_RESET;
      ch2_sel_reg <= `TBIO_SEL_RESET;
      ch1_sel_wr_reg <= 1'h0;
      ch2_sel_wr_reg <= 1'h0;
    end else begin
      ch1_sel_wr_reg <= wr_ch1_ctl & wstrb_reg[0];
      ch2_sel_wr_reg <= wr_ch2_ctl & wstrb_reg[0];
      if (wr_ch1_ctl && wstrb_reg[0])
        ch1_sel_reg <= wdata_reg[`TBIO_SEL_MSB:`TBIO_SEL_LSB]; // [R08]
      if (wr_ch2_ctl && wstrb_reg[0])
        ch2_sel_reg <= wdata_reg[`TBIO_SEL_MSB:`TBIO_SEL_LSB]; // [R08]
    end
  end

  // Register-B write strobes, merged with the current value by lane
  always @(posedge aclk) begin
    if (!aresetn) begin
      ch1_gr_wr_reg <= 1'h0;
      ch2_gr_wr_reg <= 1'h0;
      gr_wdata_reg <= `TBIO_GRB_RESET;
    end else begin
      ch1_gr_wr_reg <= wr_ch1_grb & (|wstrb_reg[1:0]);
      ch2_gr_wr_reg <= wr_ch2_grb & (|wstrb_reg[1:0]);
      if (wr_ch1_grb)
        gr_wdata_reg <= lane_merge(ch1_gr, wdata_reg[15:0], wstrb_reg[1:0]);
      else if (wr_ch2_grb)
        gr_wdata_reg <= lane_merge(ch2_gr, wdata_reg[15:0], wstrb_reg[1:0]);
    end
  end

  // ****************************************
  // Read channel
  // ****************************************

  // Status word: synced pin levels above the driven levels
  assign status_word = {ch2_pin_sync, ch1_pin_sync, ch2_pin_b_out, ch1_pin_b_out};

  // Read data select; reserved bits read zero
  always @* begin
    rd_next = 32'h00000000;
    rd_hit_next = 1'h1;
    if (addr_is(s_axi_araddr, `TBIO_OFF_CH1_CTL))
      rd_next[`TBIO_SEL_MSB:`TBIO_SEL_LSB] = ch1_sel_reg; // [R08]
    else if (addr_is(s_axi_araddr, `TBIO_OFF_CH2_CTL))
      rd_next[`TBIO_SEL_MSB:`TBIO_SEL_LSB] = ch2_sel_reg; // [R08]
    else if (addr_is(s_axi_araddr, `TBIO_OFF_CH1_GRB))
      rd_next[15:0] = ch1_gr;
    else if (addr_is(s_axi_araddr, `TBIO_OFF_CH2_GRB))
      rd_next[15:0] = ch2_gr;
    else if (addr_is(s_axi_araddr, `TBIO_OFF_STATUS))
      rd_next[3:0] = status_word;
    else
      rd_hit_next = 1'h0;
  end

  // Read address acceptance and data return
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TBIO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h1;
      s_axi_rdata <= rd_next;
      s_axi_rresp <= resp_code(rd_hit_next);
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'h0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'h1;
    end
  end

  // ****************************************
  // Pins and channels
  // ****************************************

  // Pins come from outside the clock domain
  tbio_sync u_ch1_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(ch1_pin_b_in),
    .sync_out_reg(ch1_pin_sync)
  );

  // Same two stages for the channel-2 pin
  tbio_sync u_ch2_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(ch2_pin_b_in),
    .sync_out_reg(ch2_pin_sync)
  );

  // Channel 1 may capture on the channel-0 register-C event
  tbio_channel #(
    .HAS_LINK(1)
  ) u_ch1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel(ch1_sel_reg),
    .sel_wr(ch1_sel_wr_reg),
    .count(ch1_count),
    .pin_in(ch1_pin_sync),
    .link_event(ch0_general_reg_c_event), // [R07]
    .gr_wr(ch1_gr_wr_reg),
    .gr_wdata(gr_wdata_reg),
    .gr_reg(ch1_gr),
    .pin_out_reg(ch1_pin_b_out),
    .pin_oe_reg(ch1_pin_b_oe)
  );

  // Channel 2 has no link, so bit 2 is ignored while capturing
  tbio_channel #(
    .HAS_LINK(0)
  ) u_ch2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel(ch2_sel_reg),
    .sel_wr(ch2_sel_wr_reg),
    .count(ch2_count),
    .pin_in(ch2_pin_sync),
    .link_event(1'h0), // [R04]
    .gr_wr(ch2_gr_wr_reg),
    .gr_wdata(gr_wdata_reg),
    .gr_reg(ch2_gr),
    .pin_out_reg(ch2_pin_b_out),
    .pin_oe_reg(ch2_pin_b_oe)
  );
endmodule

// >>> sim/tbio_chk.sv
// Bus and pin checks for the register-B select block
`timescale 1ns/1ps
`include "tbio_defines.vh"
module tbio_chk (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire ch1_pin_b_out,
  input wire ch1_pin_b_oe,
  input wire ch2_pin_b_out,
  input wire ch2_pin_b_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Handshake steps of one write
  sequence s_aw;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_w;
    s_axi_wvalid && s_axi_wready;
  endsequence
  a_aw_once: assert property (s_aw |=> !s_axi_awready)
    else $error("awready stayed high");
  // Answer shows two edges on: one to hold both halves, one to raise bvalid
  a_b_follow: assert property (s_aw ##0 s_w |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_w_unmapped: assert property (s_aw ##0 s_w ##0 (s_axi_awaddr[7:2] > 6'h04)
    |-> ##2 s_axi_bresp == `TBIO_RESP_SLVERR) else $error("unmapped write accepted");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_unmapped: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[7:2] > 6'h04
    |=> s_axi_rresp == `TBIO_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  // Undriven pins sit low, so a stale level never leaks
  a_pin_quiet: assert property (!ch1_pin_b_oe && !ch2_pin_b_oe
    |-> !ch1_pin_b_out && !ch2_pin_b_out) else $error("undriven pin not low");
  a_oe_by_write: assert property ($changed(ch1_pin_b_oe) || $changed(ch2_pin_b_oe)
    |-> $past(s_axi_bvalid)) else $error("pin enable moved without a write");
endmodule
bind tbio_top tbio_chk i_tbio_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .ch1_pin_b_out, .ch1_pin_b_oe, .ch2_pin_b_out, .ch2_pin_b_oe);

// >>> sim/tbio_pins.sv
// Outside circuitry on the two register-B pins
`timescale 1ns/1ps
module tbio_pins (
  input wire [1:0] pin_out,
  input wire [1:0] pin_oe,
  input wire [1:0] ext_level,
  output wire [1:0] pin_level
);
  // Block wins while it drives; otherwise the outside source sets the line
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// >>> sim/test_tbio_top.sv
// Self-checking bench for the register-B select block
`timescale 1ns/1ps
`include "tbio_defines.vh"
module test_tbio_top;
  logic aclk = 0, aresetn = 0, ev = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic [3:0] wst = 4'hF;
  logic [15:0] cnt [2] = '{16'h0, 16'h0};
  logic [1:0] ext = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, pout, poe, pin;
  wire [31:0] s_axi_rdata;
  int n_mismatch = 0, checks = 0;
  int ch, s, k;
  logic [15:0] v, e16;
  logic eb;
  always #2.5 aclk = ~aclk;
  tbio_top i_tbio_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ch1_count(cnt[0]), .ch2_count(cnt[1]),
    .ch0_general_reg_c_event(ev), .ch1_pin_b_in(pin[0]), .ch1_pin_b_out(pout[0]),
    .ch1_pin_b_oe(poe[0]), .ch2_pin_b_in(pin[1]), .ch2_pin_b_out(pout[1]),
    .ch2_pin_b_oe(poe[1]));
  tbio_pins i_tbio_pins (.pin_out(pout), .pin_oe(poe), .ext_level(ext), .pin_level(pin));
  // ****************
  // Helpers
  // ****************
  task automatic end_sim;
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // A used-up wait is a failure, never a silent pass
  task automatic tmo(input int n);
    if (n >= 60) begin
      n_mismatch++;
      end_sim;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= wst;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1 && n < 60);
    tmo(n);
    chk("bresp", er, s_axi_bresp);
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1 && n < 60);
    tmo(n);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  // Pin level after a compare match, from the two low select bits
  function automatic logic act(input logic [1:0] m, input logic cur);
    return m == 2'h1 ? 1'b0 : m == 2'h2 ? 1'b1 : m == 2'h3 ? !cur : 1'b0;
  endfunction
  function automatic logic cap(input logic [3:0] m, input logic rise);
    return m[1] || (rise ? !m[0] : m[0]);
  endfunction
  // ****************
  // Scenarios
  // ****************
  initial begin
    v = 16'($urandom(32'h3CF4));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    for (ch = 0; ch < 2; ch++) begin
      rd(8'(ch * 4), 0, `TBIO_RESP_OKAY);
      rd(8'(8 + ch * 4), 0, `TBIO_RESP_OKAY);
    end
    rd(8'h40, 0, `TBIO_RESP_SLVERR);
    wr(8'h40, 1, `TBIO_RESP_SLVERR);
    // Every compare select, two matches each so toggling shows
    for (ch = 0; ch < 2; ch++) for (s = 0; s < 8; s++) begin
      v = 16'($urandom);
      cnt[ch] <= v + 16'h1;
      wr(8'(ch * 4), {24'h0, 4'(s), 4'h0}, `TBIO_RESP_OKAY);
      rd(8'(ch * 4), {24'h0, 4'(s), 4'h0}, `TBIO_RESP_OKAY);
      wr(8'(8 + ch * 4), {16'h0, v}, `TBIO_RESP_OKAY);
      eb = s[2] && s[1:0] != 0;
      chk("oe", s[1:0] != 0, poe[ch]);
      chk("init", eb, pout[ch]);
      repeat (2) begin
        cnt[ch] <= v;
        repeat (3) @(posedge aclk);
        eb = act(s[1:0], eb);
        chk("match", eb, pout[ch]);
        cnt[ch] <= v + 16'h1;
        @(posedge aclk);
      end
    end
    // Both channels end on toggle-from-high, so every status bit is up
    rd(8'h10, 32'h0000000F, `TBIO_RESP_OKAY);
    wr(8'h10, 32'h00000000, `TBIO_RESP_OKAY);
    rd(8'h10, 32'h0000000F, `TBIO_RESP_OKAY);
    // Pin-edge captures; channel 2 also with bit 2 set
    for (ch = 0; ch < 2; ch++) for (s = 8; s < (ch ? 16 : 12); s++) begin
      ext[ch] <= 0;
      wr(8'(ch * 4), {24'h0, 4'(s), 4'h0}, `TBIO_RESP_OKAY);
      repeat (6) @(posedge aclk);
      wr(8'(8 + ch * 4), 0, `TBIO_RESP_OKAY);
      e16 = 0;
      for (k = 0; k < 2; k++) begin
        v = 16'($urandom);
        cnt[ch] <= v;
        ext[ch] <= !k;
        repeat (5) @(posedge aclk);
        if (cap(4'(s), !k)) e16 = v;
        rd(8'(8 + ch * 4), {16'h0, e16}, `TBIO_RESP_OKAY);
      end
    end
    // Channel 1 linked to channel 0 events; its pin is ignored
    for (s = 12; s < 16; s++) begin
      wr(8'h00, {24'h0, 4'(s), 4'h0}, `TBIO_RESP_OKAY);
      wr(8'h08, 0, `TBIO_RESP_OKAY);
      ext[0] <= !ext[0];
      repeat (6) @(posedge aclk);
      rd(8'h08, 0, `TBIO_RESP_OKAY);
      v = 16'($urandom);
      cnt[0] <= v;
      ev <= 1;
      @(posedge aclk);
      ev <= 0;
      @(posedge aclk);
      rd(8'h08, {16'h0, v}, `TBIO_RESP_OKAY);
    end
    // Lane 1 alone: high byte of register B moves, the select stays
    wst = 4'h2;
    wr(8'h0C, 32'h0000AB00, `TBIO_RESP_OKAY);
    wr(8'h00, 32'h00000000, `TBIO_RESP_OKAY);
    wst = 4'hF;
    rd(8'h0C, {16'h0, 8'hAB, e16[7:0]}, `TBIO_RESP_OKAY);
    rd(8'h00, 32'h000000F0, `TBIO_RESP_OKAY);
    end_sim;
  end
endmodule
